/* verilog/tmz_pkg.sv */
package tmz_pkg;

    //------------------------------------------------------------
    // Register map
    //------------------------------------------------------------
    localparam logic [7:0] TIMER_CONTROL_ADDR = 8'h05;
    localparam logic [7:0] INT_STAT_EN_ADDR   = 8'h07;
    localparam logic [7:0] COUNT_LOW_ADDR     = 8'h0B;
    localparam logic [7:0] COUNT_HIGH_ADDR    = 8'h0C;
    localparam logic [7:0] EVT_STATUS_ADDR    = 8'h10;
    localparam logic [7:0] EVT_MASK_ADDR      = 8'h11;

    //------------------------------------------------------------
    // Field positions
    //------------------------------------------------------------
    localparam int unsigned CTL_EXT_INTERRUPT_EDGE_SELECT_BIT = 7;
    localparam int unsigned CTL_EDGE_BIT   = 6;
    localparam int unsigned CTL_SRC_BIT    = 5;
    localparam int unsigned CTL_PS_LSB     = 1;
    localparam int unsigned PS_SEL_W       = 4;
    localparam int unsigned ISE_FLAG_BIT   = 5;
    localparam int unsigned ISE_EN_BIT     = 1;
    localparam int unsigned EVT_OVF_BIT    = 0;
    localparam int unsigned EVT_EDGE_BIT   = 1;
    localparam int unsigned EVT_W          = 2;

    //------------------------------------------------------------
    // Reset values
    //------------------------------------------------------------
    localparam logic [7:0]  CTL_RST      = 8'h00;
    localparam logic [1:0]  EVT_MASK_RST = 2'h0;
    localparam logic [15:0] COUNT_RST    = 16'h0000;

    //------------------------------------------------------------
    // Timing
    //------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 100;
    localparam int unsigned TOSC_NS       = 10;
    localparam int unsigned SYNC_MIN_TOSC = 3;
    localparam int unsigned SYNC_MAX_TOSC = 7;
    // Least time rounds up, longest rounds down
    localparam int unsigned SYNC_MIN_CLK  =
        (SYNC_MIN_TOSC * TOSC_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned SYNC_MAX_CLK  =
        (SYNC_MAX_TOSC * TOSC_NS * CLK_MHZ) / 1000;
    localparam logic [1:0]  PHASE_LAST    = 2'h3;

endpackage

/* verilog/tmz_prescaler.sv */
module tmz_prescaler #(
    parameter int unsigned PS_W  = 8,
    parameter int unsigned SEL_W = 4
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic             clear,
    input  wire logic             step,
    input  wire logic [SEL_W-1:0] sel,
    output logic                  pulse,
    output logic      [PS_W-1:0]  count
);

    logic [PS_W-1:0] lim;

    //------------------------------------------------------------
    // Parameter check
    //------------------------------------------------------------
    if (PS_W < 1 || (1 << SEL_W) <= PS_W)
        $error("tmz_prescaler: select field too narrow for PS_W");

    //------------------------------------------------------------
    // Terminal count: select n gives 2**n steps, saturating at 2**PS_W
    //------------------------------------------------------------
    for (genvar g = 0; g < PS_W; g++)
    begin : g_lim
        assign lim[g] = (32'(sel) > g);
    end

    // Counter; a clear always beats a step.
    // A count left above a newly lowered limit ends at once, not after a full wrap
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count <= '0;
        else if (clear)
            count <= '0;
        else if (step)
            count <= (count >= lim) ? '0 : count + 1'b1;
    end

    // One pulse per full ratio
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            pulse <= 1'b0;
        else
            pulse <= step && !clear && (count >= lim);
    end

endmodule

/* verilog/tmz_timer.sv */
module tmz_timer (
    input  wire logic       clock,
    input  wire logic       rst,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_en,
    input  wire logic       rd_en,
    output logic      [7:0] rdata,
    input  wire logic       external_count_pin,
    input  wire logic       vector_ack,
    output logic            ovf_irq,
    output logic            irq
);
    import tmz_pkg::*;

    localparam int LAT_MIN = SYNC_MIN_CLK - 2;
    localparam int LAT_MAX = SYNC_MAX_CLK - 2;

    logic [7:0]       timer_control_r;
    logic             overflow_enable_r;
    logic             overflow_flag_r;
    logic [EVT_W-1:0] evt_status_r;
    logic [EVT_W-1:0] evt_mask_r;
    logic [7:0]       count_low_r;
    logic [7:0]       count_high_r;
    logic             inh_low_r;
    logic             inh_high_r;
    logic [1:0]       phase_r;
    logic             pin_s1_r;
    logic             pin_s2_r;
    logic             pin_prev_r;
    logic             prescaler_output_r;
    logic             samp_r;
    logic             ps_pulse;
    logic [7:0]       ps_count;

    //------------------------------------------------------------
    // Decode
    //------------------------------------------------------------
    logic wr_ctl;
    logic wr_ise;
    logic wr_low;
    logic wr_high;
    logic wr_evt;
    logic wr_mask;
    assign wr_ctl  = wr_en && (addr == TIMER_CONTROL_ADDR);
    assign wr_ise  = wr_en && (addr == INT_STAT_EN_ADDR);
    assign wr_low  = wr_en && (addr == COUNT_LOW_ADDR);
    assign wr_high = wr_en && (addr == COUNT_HIGH_ADDR);
    assign wr_evt  = wr_en && (addr == EVT_STATUS_ADDR);
    assign wr_mask = wr_en && (addr == EVT_MASK_ADDR);

    // Control fields
    logic                clk_src;
    logic                edge_rise;
    logic [PS_SEL_W-1:0] ps_sel;
    assign clk_src   = timer_control_r[CTL_SRC_BIT];
    assign edge_rise = timer_control_r[CTL_EDGE_BIT];
    assign ps_sel    = timer_control_r[CTL_PS_LSB +: PS_SEL_W];

    //------------------------------------------------------------
    // Phase clocks: four core periods per instruction cycle
    //------------------------------------------------------------
    logic half_en;
    logic cyc_en;
    assign half_en = phase_r[0];
    assign cyc_en  = (phase_r == PHASE_LAST);

    // Free-running phase divider
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            phase_r <= 2'h0;
        else
            phase_r <= phase_r + 2'h1;
    end

    //------------------------------------------------------------
    // External pin
    //------------------------------------------------------------
    // Two-stage synchroniser, then a third stage for edge detect
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r   <= 1'b0;
            pin_s2_r   <= 1'b0;
            pin_prev_r <= 1'b0;
        end
        else
        begin
            pin_s1_r   <= external_count_pin;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
        end
    end

    // Active edge by polarity select
    logic ext_edge;
    assign ext_edge = edge_rise ? (pin_s2_r && !pin_prev_r)
                                : (!pin_s2_r && pin_prev_r);

    //------------------------------------------------------------
    // Prescaler
    //------------------------------------------------------------
    logic ps_step;
    logic ps_clear;
    assign ps_step  = clk_src ? cyc_en : ext_edge;
    assign ps_clear = wr_low || wr_high;

    // Ratio is read live, so it may change at any time
    tmz_prescaler #(
        .PS_W  (8),
        .SEL_W (PS_SEL_W)
    ) u_ps (
        .clock (clock),
        .rst   (rst),
        .clear (ps_clear),
        .step  (ps_step),
        .sel   (ps_sel),
        .pulse (ps_pulse),
        .count (ps_count)
    );

    // External path: output level resampled on the phase clocks.
    // A level toggle survives the sampling gap where a pulse would not.
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            prescaler_output_r <= 1'b0;
        else if (ps_pulse && !clk_src)
            prescaler_output_r <= !prescaler_output_r;
    end

    // Sampled twice per instruction cycle
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            samp_r <= 1'b0;
        else if (half_en)
            samp_r <= prescaler_output_r;
    end

    logic inc_tick;
    assign inc_tick = clk_src ? ps_pulse
                              : (half_en && (samp_r != prescaler_output_r));

    //------------------------------------------------------------
    // Counter halves
    //------------------------------------------------------------
    logic low_go;
    logic high_go;
    logic carry;
    logic ovf_evt;
    assign low_go  = !wr_low && !inh_low_r;
    assign high_go = !wr_high && !inh_high_r;
    assign carry   = low_go && (count_low_r == 8'hFF);
    assign ovf_evt = inc_tick && carry && high_go && (count_high_r == 8'hFF);

    // Inhibit stands from the write until the first cyc_en phase after it
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            inh_low_r  <= 1'b0;
            inh_high_r <= 1'b0;
        end
        else
        begin
            inh_low_r  <= wr_low || (inh_low_r && !cyc_en);
            inh_high_r <= wr_high || (inh_high_r && !cyc_en);
        end
    end

    // Low byte
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_low_r <= COUNT_RST[7:0];
        else if (wr_low)
            count_low_r <= wdata;
        else if (inc_tick && low_go)
            count_low_r <= count_low_r + 8'h01;
    end

    // High byte takes the carry only when it is free to move
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            count_high_r <= COUNT_RST[15:8];
        else if (wr_high)
            count_high_r <= wdata;
        else if (inc_tick && carry && high_go)
            count_high_r <= count_high_r + 8'h01;
    end

    //------------------------------------------------------------
    // Registers
    //------------------------------------------------------------
    // Timer control; bit 0 is not stored
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            timer_control_r <= CTL_RST;
        else if (wr_ctl)
            timer_control_r <= {wdata[7:1], 1'b0};
    end

    // Overflow enable
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            overflow_enable_r <= 1'b0;
        else if (wr_ise)
            overflow_enable_r <= wdata[ISE_EN_BIT];
    end

    // Overflow flag: a wrap beats the vector ack and a write
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            overflow_flag_r <= 1'b0;
        else if (ovf_evt)
            overflow_flag_r <= 1'b1;
        else if (vector_ack)
            overflow_flag_r <= 1'b0;
        else if (wr_ise)
            overflow_flag_r <= wdata[ISE_FLAG_BIT];
    end

    // Sticky events, write one to clear, set wins
    logic [EVT_W-1:0] evt_set;
    assign evt_set[EVT_OVF_BIT]  = ovf_evt;
    assign evt_set[EVT_EDGE_BIT] = ext_edge && !clk_src;

    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            evt_status_r <= '0;
        else
            evt_status_r <= evt_set |
                (evt_status_r & ~(wr_evt ? wdata[EVT_W-1:0] : '0));
    end

    // Event mask
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            evt_mask_r <= EVT_MASK_RST;
        else if (wr_mask)
            evt_mask_r <= wdata[EVT_W-1:0];
    end

    // Interrupt outputs, one cycle behind their causes
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            ovf_irq <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            ovf_irq <= overflow_flag_r && overflow_enable_r;
            irq     <= |(evt_status_r & evt_mask_r);
        end
    end

    //------------------------------------------------------------
    // Read port: data only in the cycle after the strobe
    //------------------------------------------------------------
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
            rdata <= 8'h00;
        else if (!rd_en)
            rdata <= 8'h00;
        else
        begin
            unique case (addr)
                TIMER_CONTROL_ADDR: rdata <= timer_control_r;
                INT_STAT_EN_ADDR:   rdata <= 8'(
                    (32'(overflow_flag_r) << ISE_FLAG_BIT) |
                    (32'(overflow_enable_r) << ISE_EN_BIT));
                COUNT_LOW_ADDR:     rdata <= count_low_r;
                COUNT_HIGH_ADDR:    rdata <= count_high_r;
                EVT_STATUS_ADDR:    rdata <= {6'h00, evt_status_r};
                EVT_MASK_ADDR:      rdata <= {6'h00, evt_mask_r};
                default:            rdata <= 8'h00;
            endcase
        end
    end

    //------------------------------------------------------------
    // Checks
    //------------------------------------------------------------
    // Synced edge seen with nothing else stirring the counter
    sequence s_clean_edge;
        ext_edge && !clk_src && (ps_sel == 4'h0) && !ps_clear;
    endsequence

    sequence s_quiet;
        !wr_ctl && !wr_low && !wr_high && !inh_low_r;
    endsequence

    property p_ext_latency;
        @(posedge clock) disable iff (rst)
        s_clean_edge ##0 s_quiet [*2] |-> ##[LAT_MIN:LAT_MAX] inc_tick;
    endproperty
    a_ext_latency: assert property (p_ext_latency)
        else $error("external edge not counted in time");

    property p_ext_sampled;
        @(posedge clock) disable iff (rst)
        (!clk_src && inc_tick) |-> half_en ##1 (samp_r == $past(prescaler_output_r));
    endproperty
    a_ext_sampled: assert property (p_ext_sampled)
        else $error("external count taken off the phase clock");

    property p_int_source;
        @(posedge clock) disable iff (rst)
        (clk_src && $past(clk_src) && inc_tick) |-> $past(cyc_en);
    endproperty
    a_int_source: assert property (p_int_source)
        else $error("internal count not on the instruction clock");

    property p_ps_clear;
        @(posedge clock) disable iff (rst)
        (wr_low || wr_high) |=> (ps_count == 8'h00) && !ps_pulse;
    endproperty
    a_ps_clear: assert property (p_ps_clear)
        else $error("prescaler not cleared by counter write");

    property p_low_hold;
        @(posedge clock) disable iff (rst)
        (inh_low_r && !wr_low) |=> (count_low_r == $past(count_low_r));
    endproperty
    a_low_hold: assert property (p_low_hold)
        else $error("low byte moved in the cycle after its write");

    property p_wrap;
        @(posedge clock) disable iff (rst)
        (inc_tick && {count_high_r, count_low_r} == 16'hFFFF &&
         low_go && high_go && !vector_ack)
        |=> ({count_high_r, count_low_r} == 16'h0000) && overflow_flag_r;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("wrap did not clear counter and set flag");

    property p_ack;
        @(posedge clock) disable iff (rst)
        (vector_ack && !ovf_evt) |=> !overflow_flag_r ##1 !ovf_irq;
    endproperty
    a_ack: assert property (p_ack)
        else $error("vector ack did not clear overflow flag");

    property p_one_to_one;
        @(posedge clock) disable iff (rst)
        (ps_step && !ps_clear && ps_sel == 4'h0) |=> ps_pulse;
    endproperty
    a_one_to_one: assert property (p_one_to_one)
        else $error("one-to-one ratio dropped a step");

    property p_load16;
        @(posedge clock) disable iff (rst)
        (wr_low ##1 wr_high) |=>
            ({count_high_r, count_low_r} == {$past(wdata), $past(wdata, 2)});
    endproperty
    a_load16: assert property (p_load16)
        else $error("sixteen-bit load not held");

    property p_read_low;
        @(posedge clock) disable iff (rst)
        (rd_en && addr == COUNT_LOW_ADDR) |=> (rdata == $past(count_low_r)) ##1
            (rdata == 8'h00 || $past(rd_en));
    endproperty
    a_read_low: assert property (p_read_low)
        else $error("low byte read returned wrong data");

endmodule

/* test/tmz_pulse_src.sv */
// External pulse source that drives the count pin
module tmz_pulse_src #(
    parameter int unsigned HOLD = 6
) (
    input  wire logic clock,
    output logic      pin
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pin idles high, so the first falling edge is a real edge
    initial pin = 1'b1;

    //------------------------------------------------------------
    // Level driver
    //------------------------------------------------------------
    // Each level stands HOLD clocks; shorter levels could slip past the sampler
    task automatic drive(input logic lvl);
        @(posedge clock);
        pin <= lvl;
        repeat (HOLD) @(posedge clock);
    endtask
endmodule

/* test/tmz_timer_test.sv */
`define CHK(got, exp) \
    begin \
        checks++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("CHECK FAILED t=%0t got=%0h exp=%0h", $time, got, exp); \
        end \
    end

module tmz_timer_test;
    timeunit 1ns;
    timeprecision 1ns;
    import tmz_pkg::*;

    localparam int TIMEOUT = 40000;
    localparam logic [7:0] RST_ADDR [8] = '{8'h05, 8'h06, 8'h07, 8'h0B, 8'h0C, 8'h10, 8'h11, 8'h20};
    localparam int PS_LIST [6] = '{0, 1, 3, 7, 8, 15};
    localparam logic [7:0] EDGE_CTL [3] = '{8'h00, 8'h40, 8'h02};
    localparam logic [7:0] EDGE_EXP [3] = '{8'h02, 8'h02, 8'h01};

    logic       clock      = 1'b0;
    logic       rst        = 1'b1;
    logic [7:0] addr       = 8'h00;
    logic [7:0] wdata      = 8'h00;
    logic       wr_en      = 1'b0;
    logic       rd_en      = 1'b0;
    logic       vector_ack = 1'b0;
    logic [7:0] rdata;
    logic       pin;
    logic       ovf_irq;
    logic       irq;
    int         num_errors = 0;
    int         checks     = 0;
    int         cycles     = 0;

    tmz_timer dut_u (
        .clock              (clock),
        .rst                (rst),
        .addr               (addr),
        .wdata              (wdata),
        .wr_en              (wr_en),
        .rd_en              (rd_en),
        .rdata              (rdata),
        .external_count_pin (pin),
        .vector_ack         (vector_ack),
        .ovf_irq            (ovf_irq),
        .irq                (irq)
    );

    tmz_pulse_src src_u (
        .clock (clock),
        .pin   (pin)
    );

    // 100 MHz core clock
    always #5 clock = ~clock;

    // Hang guard
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == TIMEOUT)
        begin
            num_errors++;
            report_and_stop();
        end
    end

    //------------------------------------------------------------
    // Bus tasks
    //------------------------------------------------------------
    // Write leaves the strobe up so two writes land back to back
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b1;
        rd_en <= 1'b0;
        addr  <= a;
        wdata <= d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clock);
        wr_en <= 1'b0;
        rd_en <= 1'b1;
        addr  <= a;
        @(posedge clock);
        rd_en <= 1'b0;
        #1;
        d = rdata;
    endtask

    task automatic chk_rd(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `CHK(d, exp)
    endtask

    task automatic cyc(input int n);
        repeat (n)
        begin
            @(posedge clock);
            wr_en <= 1'b0;
            rd_en <= 1'b0;
        end
        // Step off the edge so outputs are read once settled
        #1;
    endtask

    task automatic report_and_stop();
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    //------------------------------------------------------------
    // Main sequence
    //------------------------------------------------------------
    initial
    begin
        logic [7:0] a;
        logic [7:0] b;
        int         per;
        int         found;
        logic       lvl;
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        // Reset values, unmapped places read zero
        for (int i = 0; i < 8; i++)
            chk_rd(RST_ADDR[i], 8'h00);
        wr(8'h20, 8'hFF);
        wr(TIMER_CONTROL_ADDR, 8'hFF);
        chk_rd(8'h20, 8'h00);
        chk_rd(TIMER_CONTROL_ADDR, 8'hFE);
        // Internal clock: reads spaced three periods apart differ by exactly three
        for (int i = 0; i < 6; i++)
        begin
            per = 4 << ((PS_LIST[i] > 7) ? 8 : PS_LIST[i]);
            wr(COUNT_LOW_ADDR, 8'h00);
            wr(COUNT_HIGH_ADDR, 8'h00);
            wr(TIMER_CONTROL_ADDR, 8'h20 | 8'(PS_LIST[i] << 1));
            cyc(per + 8);
            rd(COUNT_LOW_ADDR, a);
            cyc(3 * per - 2);
            rd(COUNT_LOW_ADDR, b);
            `CHK(8'(b - a), 8'h03)
        end
        // Repeated byte writes keep the prescaler from ever reaching its end
        wr(TIMER_CONTROL_ADDR, 8'h26);
        wr(COUNT_LOW_ADDR, 8'h00);
        wr(COUNT_HIGH_ADDR, 8'h00);
        repeat (20)
        begin
            wr(COUNT_HIGH_ADDR, 8'h00);
            cyc(20);
        end
        chk_rd(COUNT_LOW_ADDR, 8'h00);
        // External pin, no edges: loaded value holds, then resumes
        wr(TIMER_CONTROL_ADDR, 8'h00);
        wr(COUNT_LOW_ADDR, 8'h34);
        wr(COUNT_HIGH_ADDR, 8'h12);
        cyc(6);
        chk_rd(COUNT_LOW_ADDR, 8'h34);
        chk_rd(COUNT_HIGH_ADDR, 8'h12);
        src_u.drive(1'b0);
        cyc(4);
        chk_rd(COUNT_LOW_ADDR, 8'h35);
        // Edge to increment delay, polled with a read every cycle
        src_u.drive(1'b1);
        wr(COUNT_LOW_ADDR, 8'h00);
        wr(COUNT_HIGH_ADDR, 8'h00);
        cyc(6);
        found = 0;
        fork
            src_u.drive(1'b0);
            begin
                @(posedge clock);
                rd_en <= 1'b1;
                addr  <= COUNT_LOW_ADDR;
                for (int k = 1; k <= 12; k++)
                begin
                    @(posedge clock);
                    #1;
                    if (rdata === 8'h01 && found == 0)
                        found = k;
                end
            end
        join
        cyc(1);
        `CHK(found >= SYNC_MIN_CLK + 1 && found <= SYNC_MAX_CLK + 1, 1'b1)
        // Edge polarity and external prescale
        for (int i = 0; i < 3; i++)
        begin
            lvl = EDGE_CTL[i][CTL_EDGE_BIT];
            wr(TIMER_CONTROL_ADDR, EDGE_CTL[i]);
            cyc(1);
            src_u.drive(lvl);
            wr(COUNT_LOW_ADDR, 8'h00);
            wr(COUNT_HIGH_ADDR, 8'h00);
            cyc(6);
            src_u.drive(~lvl);
            cyc(4);
            chk_rd(COUNT_LOW_ADDR, 8'h00);
            src_u.drive(lvl);
            src_u.drive(~lvl);
            src_u.drive(lvl);
            cyc(4);
            chk_rd(COUNT_LOW_ADDR, EDGE_EXP[i]);
        end
        // Wrap, flag, vector acknowledge, sticky events and mask
        wr(TIMER_CONTROL_ADDR, 8'h00);
        cyc(1);
        src_u.drive(1'b1);
        wr(INT_STAT_EN_ADDR, 8'h02);
        wr(EVT_MASK_ADDR, 8'h01);
        wr(COUNT_LOW_ADDR, 8'hFF);
        wr(COUNT_HIGH_ADDR, 8'hFF);
        cyc(6);
        src_u.drive(1'b0);
        cyc(4);
        chk_rd(COUNT_LOW_ADDR, 8'h00);
        chk_rd(COUNT_HIGH_ADDR, 8'h00);
        chk_rd(INT_STAT_EN_ADDR, 8'h22);
        `CHK(ovf_irq, 1'b1)
        `CHK(irq, 1'b1)
        chk_rd(EVT_STATUS_ADDR, 8'h03);
        @(posedge clock);
        vector_ack <= 1'b1;
        @(posedge clock);
        vector_ack <= 1'b0;
        cyc(2);
        chk_rd(INT_STAT_EN_ADDR, 8'h02);
        `CHK(ovf_irq, 1'b0)
        wr(EVT_STATUS_ADDR, 8'h01);
        cyc(2);
        `CHK(irq, 1'b0)
        chk_rd(EVT_STATUS_ADDR, 8'h02);
        wr(EVT_MASK_ADDR, 8'h02);
        cyc(2);
        `CHK(irq, 1'b1)
        wr(EVT_STATUS_ADDR, 8'h02);
        cyc(2);
        `CHK(irq, 1'b0)
        // Low then high read with a low-byte wrap in between, then reread
        src_u.drive(1'b1);
        wr(COUNT_LOW_ADDR, 8'hFF);
        wr(COUNT_HIGH_ADDR, 8'h12);
        cyc(6);
        rd(COUNT_LOW_ADDR, a);
        src_u.drive(1'b0);
        cyc(4);
        rd(COUNT_HIGH_ADDR, b);
        `CHK(a, 8'hFF)
        `CHK(b, 8'h13)
        chk_rd(COUNT_LOW_ADDR, 8'h00);
        chk_rd(COUNT_HIGH_ADDR, 8'h13);
        report_and_stop();
    end
endmodule
